// ==== include/eeu_pkg.sv ====
// Package for the data EEPROM unlock and control block.
// Assumes a single 100 MHz clock and a plain word-wide register port.
package eeu_pkg;
	// ****************************************************************
	// Register map (word index on the register port)
	// ****************************************************************
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_KEY = 4'h1;
	localparam logic [3:0] OFS_ADDRESS = 4'h2;
	localparam logic [3:0] OFS_WDATA = 4'h3;
	localparam logic [3:0] OFS_RDATA = 4'h4;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h5;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'h6;
	localparam logic [3:0] OFS_IRQ_CLEAR = 4'h7;
	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int BIT_START = 15;
	localparam int BIT_WREN = 14;
	localparam int BIT_ERROR = 13;
	localparam int OP_LSB = 0;
	localparam int OP_W = 3;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	// ****************************************************************
	// Unlock keys and memory map
	// ****************************************************************
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [23:0] EE_TOP = 24'h7FFFFF;
	localparam logic [23:0] EE_BASE_LARGE = 24'h7FFE00;
	localparam logic [23:0] EE_BASE_SMALL = 24'h7FFF00;
	localparam int WORDS_LARGE = 256;
	localparam int WORDS_SMALL = 128;
	// ****************************************************************
	// Operation codes and timing
	// ****************************************************************
	typedef enum logic [2:0] {
		EEU_OP_ERASE_WRITE = 3'b100,
		EEU_OP_ERASE = 3'b000,
		EEU_OP_WRITE = 3'b001
	} eeu_op_t;
	localparam int OP_TIME_NS = 4000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_W = 2;
endpackage

// ==== hw/eeu_array.sv ====
// Word-wide EEPROM cell array with erase, program and combined cycles.
// Latches the operation inputs at start, so the caller may change them while busy.
`timescale 1ns/1ps
module eeu_array #(
	parameter int WORDS = 256,
	parameter int AW = 8,
	parameter int CYCLES = eeu_pkg::OP_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [2:0] op,
	input wire logic [AW-1:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [15:0] rdata,
	output logic busy,
	output logic done,
	output logic fail
);
	// ****************************************************************
	// Storage and cycle timer
	// ****************************************************************
	logic [15:0] mem [WORDS];
	logic [15:0] timer;
	logic [2:0] op_q;
	logic [AW-1:0] addr_q;
	logic [15:0] data_q;
	wire op_ok = (op == eeu_pkg::EEU_OP_ERASE) ||
		(op == eeu_pkg::EEU_OP_WRITE) ||
		(op == eeu_pkg::EEU_OP_ERASE_WRITE);
	wire finish = busy && (timer == 16'h0001);
	wire in_range = (32'(waddr) < WORDS);
	assign rdata = mem[raddr];

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
			timer <= 16'h0000;
			op_q <= 3'h0;
			addr_q <= '0;
			data_q <= 16'h0000;
		end else begin
			done <= finish;
			fail <= start && !(op_ok && in_range);
			if (start && op_ok && in_range && !busy) begin
				busy <= 1'b1;
				timer <= 16'(CYCLES);
				op_q <= op;
				addr_q <= waddr;
				data_q <= wdata;
			end else if (finish) begin
				busy <= 1'b0;
				timer <= 16'h0000;
			end else if (busy) begin
				timer <= timer - 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (finish) begin
			case (op_q)
				eeu_pkg::EEU_OP_ERASE: mem[addr_q] <= 16'hFFFF;
				eeu_pkg::EEU_OP_WRITE: mem[addr_q] <= mem[addr_q] & data_q;
				eeu_pkg::EEU_OP_ERASE_WRITE: mem[addr_q] <= data_q;
				default: mem[addr_q] <= mem[addr_q];
			endcase
		end
	end
endmodule

// ==== hw/eeu_top.sv ====
// Data EEPROM unlock and control block with its register port.
// Assumes one clock, synchronous register strobes, async high reset.
`timescale 1ns/1ps
module eeu_top #(
	parameter bit LARGE = 1'b1,
	parameter int AW = 8,
	parameter int CYCLES = eeu_pkg::OP_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	output logic irq,
	output logic busy
);
	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int WORDS = LARGE ? eeu_pkg::WORDS_LARGE :
		eeu_pkg::WORDS_SMALL;
	localparam logic [23:0] BASE = LARGE ? eeu_pkg::EE_BASE_LARGE :
		eeu_pkg::EE_BASE_SMALL;

	typedef enum logic [1:0] {
		EEU_LOCKED = 2'b00,
		EEU_HALF = 2'b01,
		EEU_OPEN = 2'b10
	} eeu_lock_t;

	// ****************************************************************
	// Registers and decode
	// ****************************************************************
	eeu_lock_t lock, next_lock;
	logic [15:0] control;
	logic [23:0] target;
	logic [15:0] wdata_q;
	logic [eeu_pkg::IRQ_W-1:0] irq_status;
	logic [eeu_pkg::IRQ_W-1:0] irq_enable;
	logic launch;
	wire [15:0] arr_rdata;
	wire arr_busy;
	wire arr_done;
	wire arr_fail;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a == o);
	endfunction

	wire wr_ctl = reg_write && hit(reg_addr, eeu_pkg::OFS_CONTROL);
	wire wr_key = reg_write && hit(reg_addr, eeu_pkg::OFS_KEY);
	wire key1 = wr_key && (reg_wdata[7:0] == eeu_pkg::KEY_FIRST);
	wire key2 = wr_key && (reg_wdata[7:0] == eeu_pkg::KEY_SECOND);
	wire ctl_ok = wr_ctl && (lock == EEU_OPEN) && !arr_busy;
	wire go = ctl_ok && reg_wdata[eeu_pkg::BIT_START] &&
		reg_wdata[eeu_pkg::BIT_WREN];
	wire [23:0] offset = target - BASE;
	wire in_map = (target >= BASE) && (target <= eeu_pkg::EE_TOP);
	wire [AW-1:0] word_idx = offset[AW-1:0];
	wire [eeu_pkg::IRQ_W-1:0] events = {arr_fail, arr_done};
	wire [eeu_pkg::IRQ_W-1:0] clr_mask = (reg_write &&
		hit(reg_addr, eeu_pkg::OFS_IRQ_CLEAR)) ?
		reg_wdata[eeu_pkg::IRQ_W-1:0] : '0;

	// ****************************************************************
	// Unlock sequence
	// ****************************************************************
	always_comb begin
		next_lock = lock;
		case (lock)
			EEU_LOCKED: begin
				if (key1) begin
					next_lock = EEU_HALF;
				end
			end
			EEU_HALF: begin
				if (key2) begin
					next_lock = EEU_OPEN;
				end else if (reg_write) begin
					next_lock = key1 ? EEU_HALF : EEU_LOCKED;
				end
			end
			EEU_OPEN: begin
				next_lock = key1 ? EEU_HALF : EEU_LOCKED;
			end
			default: begin
				next_lock = EEU_LOCKED;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			lock <= EEU_LOCKED;
		end else begin
			lock <= next_lock;
		end
	end

	// ****************************************************************
	// Control, address and data registers
	// ****************************************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			control <= eeu_pkg::CONTROL_RESET;
			target <= 24'h000000;
			wdata_q <= 16'h0000;
			launch <= 1'b0;
		end else begin
			launch <= go;
			if (ctl_ok) begin
				control[eeu_pkg::BIT_START] <= go;
				control[eeu_pkg::BIT_WREN] <= reg_wdata[eeu_pkg::BIT_WREN];
				control[eeu_pkg::OP_LSB +: eeu_pkg::OP_W] <=
					reg_wdata[eeu_pkg::OP_LSB +: eeu_pkg::OP_W];
			end else if (launch && !in_map) begin
				control[eeu_pkg::BIT_START] <= 1'b0;
			end else if (arr_done || arr_fail) begin
				control[eeu_pkg::BIT_START] <= 1'b0;
			end
			if (go) begin
				control[eeu_pkg::BIT_ERROR] <= 1'b0;
			end else if (arr_fail || (launch && !in_map)) begin
				control[eeu_pkg::BIT_ERROR] <= 1'b1;
			end
			if (reg_write && hit(reg_addr, eeu_pkg::OFS_ADDRESS)) begin
				target <= {8'h7F, reg_wdata};
			end
			if (reg_write && hit(reg_addr, eeu_pkg::OFS_WDATA)) begin
				wdata_q <= reg_wdata;
			end
		end
	end

	// ****************************************************************
	// Interrupt status and enable
	// ****************************************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_status <= '0;
			irq_enable <= '0;
			irq <= 1'b0;
			busy <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~clr_mask) | events;
			if (reg_write && hit(reg_addr, eeu_pkg::OFS_IRQ_ENABLE)) begin
				irq_enable <= reg_wdata[eeu_pkg::IRQ_W-1:0];
			end
			irq <= |(((irq_status & ~clr_mask) | events) & irq_enable);
			busy <= arr_busy || launch;
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (reg_read) begin
			case (reg_addr)
				eeu_pkg::OFS_CONTROL: reg_rdata <= control;
				eeu_pkg::OFS_ADDRESS: reg_rdata <= target[15:0];
				eeu_pkg::OFS_WDATA: reg_rdata <= wdata_q;
				eeu_pkg::OFS_RDATA: reg_rdata <= in_map ? arr_rdata :
					16'h0000;
				eeu_pkg::OFS_IRQ_STATUS: reg_rdata <=
					16'(irq_status);
				eeu_pkg::OFS_IRQ_ENABLE: reg_rdata <=
					16'(irq_enable);
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ****************************************************************
	// Cell array runs beside the CPU
	// ****************************************************************
	eeu_array #(
		.WORDS(WORDS),
		.AW(AW),
		.CYCLES(CYCLES)
	) u_array (
		.core_clk(core_clk),
		.reset(reset),
		.start(launch && in_map),
		.op(control[eeu_pkg::OP_LSB +: eeu_pkg::OP_W]),
		.waddr(word_idx),
		.wdata(wdata_q),
		.raddr(word_idx),
		.rdata(arr_rdata),
		.busy(arr_busy),
		.done(arr_done),
		.fail(arr_fail)
	);
endmodule

// ==== sim/eeu_props.sv ====
// Checker for the EEPROM unlock block, bound to its top module.
// Assumes synchronous register strobes and an async high reset.
`timescale 1ns/1ps
module eeu_props #(
	parameter int CYCLES = 8
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic irq,
	input wire logic busy
);
	// ****************************************************************
	// Mirrors of unlock state and plain registers
	// ****************************************************************
	logic armed, key_done;
	logic [1:0] en_q, en_d;
	logic [15:0] adr_q;
	int bcnt;
	wire wr_key = reg_write && reg_addr == eeu_pkg::OFS_KEY;
	wire ok_launch = reg_write && reg_addr == eeu_pkg::OFS_CONTROL &&
		key_done && reg_wdata[15] && reg_wdata[14];
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			armed <= 1'b0;
			key_done <= 1'b0;
			en_q <= 2'h0;
			en_d <= 2'h0;
			adr_q <= 16'h0000;
			bcnt <= 0;
		end else begin
			if (reg_write)
				armed <= wr_key && reg_wdata[7:0] == eeu_pkg::KEY_FIRST;
			key_done <= wr_key && armed &&
				reg_wdata[7:0] == eeu_pkg::KEY_SECOND;
			if (reg_write && reg_addr == eeu_pkg::OFS_IRQ_ENABLE)
				en_q <= reg_wdata[1:0];
			if (reg_write && reg_addr == eeu_pkg::OFS_ADDRESS)
				adr_q <= reg_wdata;
			en_d <= en_q;
			bcnt <= busy ? bcnt + 1 : 0;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 0)
		else $error("read data not zero outside read answer");
	key_hidden_a: assert property (reg_read && reg_addr == eeu_pkg::OFS_KEY
		|=> reg_rdata == 16'h0000) else $error("key register readable");
	addr_back_a: assert property (reg_read && reg_addr == eeu_pkg::OFS_ADDRESS
		|=> reg_rdata == adr_q) else $error("address readback wrong");
	en_back_a: assert property (reg_read && reg_addr == eeu_pkg::OFS_IRQ_ENABLE
		|=> reg_rdata[1:0] == en_q) else $error("enable readback wrong");
	busy_cause_a: assert property ($rose(busy) |-> $past(ok_launch) ||
		$past(ok_launch, 2) || $past(ok_launch, 3))
		else $error("cycle started without unlock");
	busy_bound_a: assert property (bcnt <= CYCLES + 2)
		else $error("busy lasts too long");
	irq_enabled_a: assert property (irq |-> (en_q | en_d) != 2'h0)
		else $error("interrupt while masked");
	irq_clear_a: assert property (reg_write && reg_wdata[1:0] == 2'h3 &&
		reg_addr == eeu_pkg::OFS_IRQ_CLEAR && !busy && !$past(busy) &&
		!$past(busy, 2) |=> ##1 !irq) else $error("interrupt not cleared");
	cover property (ok_launch);
	cover property ($rose(irq));
	cover property (reg_read && reg_addr == eeu_pkg::OFS_KEY);
endmodule
bind eeu_top eeu_props #(.CYCLES(CYCLES)) eeu_props_inst (
	.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .irq(irq), .busy(busy));

// ==== sim/eeu_top_tb_top.sv ====
// Self-checking bench for the EEPROM unlock block.
// Assumes the package is compiled first and the checker is bound.
`timescale 1ns/1ps
module eeu_top_tb_top;
	// ****************************************************************
	// Bench signals, bus tasks and scenarios
	// ****************************************************************
	localparam logic [3:0] CT = eeu_pkg::OFS_CONTROL, KY = eeu_pkg::OFS_KEY,
		AD = eeu_pkg::OFS_ADDRESS, WD = eeu_pkg::OFS_WDATA,
		RD = eeu_pkg::OFS_RDATA, ST = eeu_pkg::OFS_IRQ_STATUS,
		EN = eeu_pkg::OFS_IRQ_ENABLE, CL = eeu_pkg::OFS_IRQ_CLEAR;
	logic core_clk = 0, reset = 1, reg_write = 0, reg_read = 0;
	logic [3:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0, reg_rdata;
	logic irq, busy;
	int err_count = 0, n_checks = 0;
	eeu_top #(.CYCLES(8)) eeu_top_inst (.core_clk(core_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .busy(busy));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task summarize;
		if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task check(input string nm, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
	endtask
	task idle(input int n);
		reg_write <= 1'b0;
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] m, exp);
		reg_addr <= a;
		reg_write <= 1'b0;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		@(negedge core_clk);
		check("rdata", reg_rdata & m, exp);
		@(posedge core_clk);
	endtask
	task unl(input logic [15:0] ctl);
		wr(KY, 16'h0055);
		wr(KY, 16'h00AA);
		wr(CT, ctl);
		idle(3);
	endtask
	task go(input logic [15:0] ctl);
		unl(ctl);
		check("busy", {15'h0, busy}, 16'h0001);
		rd(CT, 16'h8000, 16'h8000);
		for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge core_clk);
		idle(1);
		check("busy", {15'h0, busy}, 16'h0000);
	endtask
	task t_reset;
		rd(CT, 16'hFFFF, 16'h0000);
		rd(KY, 16'hFFFF, 16'h0000);
		rd(4'hF, 16'hFFFF, 16'h0000);
		check("busy", {15'h0, busy}, 16'h0000);
	endtask
	task t_ops;
		logic [15:0] ad[4] = '{16'hFFFF, 16'hFFFF, 16'hFE00, 16'hFFFF};
		logic [15:0] dv[4] = '{16'h1234, 16'h0F0F, 16'h5A5A, 16'h0000};
		logic [15:0] ev[4] = '{16'h1234, 16'h0204, 16'h5A5A, 16'hFFFF};
		logic [2:0] op[4] = '{3'h4, 3'h1, 3'h4, 3'h0};
		for (int i = 0; i < 4; i++) begin
			wr(AD, ad[i]);
			wr(WD, dv[i]);
			rd(AD, 16'hFFFF, ad[i]);
			go({13'h1800, op[i]});
			rd(RD, 16'hFFFF, ev[i]);
			rd(CT, 16'hA000, 16'h0000);
			rd(ST, 16'h0001, 16'h0001);
		end
	endtask
	task t_refuse;
		wr(KY, 16'h0055);
		wr(KY, 16'h00AA);
		idle(1);
		unl(16'hC004);
		wr(KY, 16'h0055);
		wr(AD, 16'hFFFF);
		wr(KY, 16'h00AA);
		wr(CT, 16'hC004);
		idle(3);
		check("busy", {15'h0, busy}, 16'h0000);
		wr(KY, 16'h0055);
		go(16'hC004);
		unl(16'hC002);
		rd(CT, 16'h2000, 16'h2000);
		rd(ST, 16'h0002, 16'h0002);
	endtask
	task t_irq;
		wr(CL, 16'h0003);
		wr(EN, 16'h0001);
		rd(EN, 16'h0003, 16'h0001);
		go(16'hC000);
		idle(2);
		check("irq", {15'h0, irq}, 16'h0001);
		wr(EN, 16'h0000);
		idle(3);
		check("irq", {15'h0, irq}, 16'h0000);
		wr(EN, 16'h0001);
		wr(CL, 16'h0003);
		idle(3);
		check("irq", {15'h0, irq}, 16'h0000);
		rd(ST, 16'h0003, 16'h0000);
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		t_reset;
		t_ops;
		t_refuse;
		t_irq;
		summarize;
	end
	initial begin
		repeat (3000) @(posedge core_clk);
		err_count++;
		summarize;
	end
endmodule
